// [rtl/pcr_top.sv]
// Power unit control: register bank, fault handling, sequencing, sync divider
//
// Operation
// - Div3 select alone divides sync clock by three
// - Div6 select alone divides sync clock by six
// - Coupling bit picks ac or dc sync
// - Serial slave only, 100 or 400 kHz
// - Answer only to slave address 0010100
// - Address bit zero selects read or write
// - Supply lockout holds all converters off
// - Overheat disables outputs until indication clears
// - Thermal event latches thermal fault flag
// - Flag set blocks rail enable writes
// - Writing flag one acts as shutdown
// - Enable pin low: outputs stay off after recovery
// - Enable pin high: restart sequence, flag kept
// - Withhold acknowledge during fault
// - Revision register: major, minor, option fields
// - Current limit: high side off until zero
// - Multi-purpose pin: enable input, optional output
`timescale 1ns/1ps
module pcr_top
#(
    parameter int SEQ_STEP_CYC = pcr_pkg::SEQ_STEP_CYC
)
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       sync_clk_i,
    input  wire logic       supply_low_lockout_i,
    input  wire logic       over_temp_i,
    input  wire logic [2:0] rail_good_i,
    input  wire logic [1:0] peak_limit_i,
    input  wire logic [1:0] coil_zero_i,
    input  wire logic       en_pin_i,
    output logic            en_pin_o,
    output logic            en_pin_oe_o,
    output logic            en_pulldown_o,
    output logic [2:0]      rail_on_o,
    output logic [1:0]      high_side_block_o,
    output logic [1:0]      low_side_hold_o,
    output logic            shutdown_out_n_o,
    output logic            sw_sync_clk_o,
    output logic            sync_locked_o,
    output logic            ac_coupled_clock_sel_o,
    output logic [2:0]      rail_one_level_code_o,
    output logic [3:0]      rail_two_level_code_o,
    output logic [3:0]      linear_level_code_o
);

    localparam int NSYNC = 13;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0]       rst_sync_ff;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic             rst_n;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    assign rst_n = rst_sync_ff[1];

    // Bus lines reset high so no false start appears at release
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= 13'h1800;
            sync_ff <= 13'h1800;
        end
        else
        begin
            meta_ff <= {scl_i, sda_i, sync_clk_i, supply_low_lockout_i, over_temp_i, en_pin_i,
                        rail_good_i, peak_limit_i, coil_zero_i};
            sync_ff <= meta_ff;
        end
    end

    wire       scl_s   = sync_ff[12];
    wire       sda_s   = sync_ff[11];
    wire       ext_s   = sync_ff[10];
    wire       supply_low_lockout_s  = sync_ff[9];
    wire       otp_s   = sync_ff[8];
    wire       pin_s   = sync_ff[7];
    wire [2:0] good_s  = sync_ff[6:4];
    wire [1:0] limit_s = sync_ff[3:2];
    wire [1:0] zero_s  = sync_ff[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Register bank

    logic [2:0] lvl_one_ff;
    logic [3:0] lvl_two_ff;
    logic [3:0] lvl_lin_ff;
    logic [3:0] rail_on_ff;
    logic       force_sd_ff;
    logic [6:0] opcfg_ff;
    logic [1:0] pincfg_ff;
    logic       therm_flag_ff;
    logic       hot_ff;
    logic       otp_d_ff;
    logic [7:0] rd_data;
    logic [7:0] ptr;
    logic       wr;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       slave_oe;

    wire wr_rail  = wr && (wr_addr == pcr_pkg::OFS_RAIL);
    wire wr_opcfg = wr && (wr_addr == pcr_pkg::OFS_OPCFG);
    wire otp_rise = otp_s & ~otp_d_ff;
    // Software setting the flag counts as a real overheat event
    wire soft_trip = wr_opcfg & wr_data[pcr_pkg::THERM_BIT];
    wire therm_evt = otp_rise | soft_trip;
    wire fault     = hot_ff | supply_low_lockout_s;

    pcr_i2c_slave u_slave
    (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n),
        .scl_i     (scl_s),
        .sda_i     (sda_s),
        .nack_i    (fault),
        .rd_data_i (rd_data),
        .sda_oe_o  (slave_oe),
        .ptr_o     (ptr),
        .wr_o      (wr),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data)
    );

    // Open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = slave_oe;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_one_ff  <= pcr_pkg::RST_LVL_ONE;
            lvl_two_ff  <= pcr_pkg::RST_LVL_TWO;
            lvl_lin_ff  <= pcr_pkg::RST_LVL_LIN;
            force_sd_ff <= 1'b0;
            opcfg_ff    <= pcr_pkg::RST_OPCFG;
            pincfg_ff   <= pcr_pkg::RST_PINCFG;
        end
        else if (wr)
        begin
            if (wr_addr == pcr_pkg::OFS_LVL_ONE)
                lvl_one_ff <= wr_data[2:0];
            else if (wr_addr == pcr_pkg::OFS_LVL_TWO)
            begin
                lvl_two_ff <= wr_data[7:4];
                lvl_lin_ff <= wr_data[3:0];
            end
            else if (wr_addr == pcr_pkg::OFS_RAIL)
                force_sd_ff <= wr_data[pcr_pkg::FORCE_SD_BIT];
            else if (wr_addr == pcr_pkg::OFS_OPCFG)
                opcfg_ff <= wr_data[7:1];
            else if (wr_addr == pcr_pkg::OFS_PINCFG)
                pincfg_ff <= wr_data[1:0];
        end
    end

    // Rail enables: cleared by a thermal event, frozen while flag is set
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rail_on_ff <= pcr_pkg::RST_RAIL_ON;
        else if (therm_evt)
            rail_on_ff <= 4'h0;
        else if (wr_rail && !therm_flag_ff)
            rail_on_ff <= wr_data[pcr_pkg::RAIL_ON_MSB:pcr_pkg::RAIL_ON_LSB];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Thermal shutdown; the set wins over a clearing write

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            therm_flag_ff <= 1'b0;
            hot_ff        <= 1'b0;
            otp_d_ff      <= 1'b0;
        end
        else
        begin
            otp_d_ff <= otp_s;
            if (therm_evt)
                therm_flag_ff <= 1'b1;
            else if (wr_opcfg)
                therm_flag_ff <= wr_data[pcr_pkg::THERM_BIT];
            if (therm_evt)
                hot_ff <= 1'b1;
            else if (!otp_s)
                hot_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable-pin startup sequence

    pcr_pkg::pcr_seq_e seq_ff;
    logic [15:0]       step_cnt_ff;

    wire pin_drive = pincfg_ff[pcr_pkg::PIN_DRIVE_BIT];
    wire pin_mode  = ~pin_drive & pin_s;
    wire step_done = (step_cnt_ff == 16'(SEQ_STEP_CYC - 1));

    // Sequence restarts by itself once the die has cooled, flag left set
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_ff      <= pcr_pkg::SEQ_IDLE;
            step_cnt_ff <= 16'h0000;
        end
        else if (!pin_mode || fault)
        begin
            seq_ff      <= pcr_pkg::SEQ_IDLE;
            step_cnt_ff <= 16'h0000;
        end
        else if (seq_ff != pcr_pkg::SEQ_ALL)
        begin
            step_cnt_ff <= step_done ? 16'h0000 : step_cnt_ff + 16'h0001;
            if (step_done || seq_ff == pcr_pkg::SEQ_IDLE)
            begin
                case (seq_ff)
                    pcr_pkg::SEQ_IDLE: seq_ff <= pcr_pkg::SEQ_ONE;
                    pcr_pkg::SEQ_ONE:  seq_ff <= pcr_pkg::SEQ_TWO;
                    pcr_pkg::SEQ_TWO:  seq_ff <= pcr_pkg::SEQ_ALL;
                    default:           seq_ff <= pcr_pkg::SEQ_ALL;
                endcase
            end
        end
    end

    wire [2:0] seq_rails = (seq_ff == pcr_pkg::SEQ_ALL) ? 3'h7 :
                           (seq_ff == pcr_pkg::SEQ_TWO) ? 3'h3 :
                           (seq_ff == pcr_pkg::SEQ_ONE) ? 3'h1 : 3'h0;
    // Register bits 7..5 map to rails one, two, linear; bit 4 turns all on
    wire [2:0] reg_rails = {rail_on_ff[1], rail_on_ff[2], rail_on_ff[3]} |
                           {3{rail_on_ff[pcr_pkg::RAIL_ALL_BIT - pcr_pkg::RAIL_ON_LSB]}};
    wire [2:0] linked    = opcfg_ff[pcr_pkg::LINK_MSB-1:pcr_pkg::LINK_LSB-1];
    wire [2:0] link_mask = {linked[0], linked[1], linked[2]} & {3{force_sd_ff}};

    // Lockout and overheat override every enable source
    assign rail_on_o = (seq_rails | reg_rails) & ~link_mask & {3{~fault}};
    assign shutdown_out_n_o = ~(force_sd_ff | fault);

    ////////////////////////////////////////////////////////////////////////////
    // Peak current limit per step-down rail

    logic [1:0] limit_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_limit
            // Low side stays on until coil current reaches zero
            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                    limit_ff[gi] <= 1'b0;
                else if (limit_s[gi])
                    limit_ff[gi] <= 1'b1;
                else if (zero_s[gi])
                    limit_ff[gi] <= 1'b0;
            end
        end
    endgenerate

    assign high_side_block_o = limit_ff;
    assign low_side_hold_o   = limit_ff;

    ////////////////////////////////////////////////////////////////////////////
    // External sync clock divider

    logic       ext_d_ff;
    logic [2:0] div_cnt_ff;
    logic       sw_clk_ff;

    wire       div3 = opcfg_ff[pcr_pkg::DIV3_BIT-1];
    wire       div6 = opcfg_ff[pcr_pkg::DIV6_BIT-1];
    wire [2:0] div_n = (div3 && !div6) ? pcr_pkg::DIV_THREE :
                       (div6 && !div3) ? pcr_pkg::DIV_SIX : 3'h0;
    wire       ext_rise = ext_s & ~ext_d_ff;
    wire       div_wrap = (div_cnt_ff >= div_n - 3'h1);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_d_ff   <= 1'b0;
            div_cnt_ff <= 3'h0;
            sw_clk_ff  <= 1'b0;
        end
        else
        begin
            ext_d_ff <= ext_s;
            if (div_n == 3'h0)
            begin
                div_cnt_ff <= 3'h0;
                sw_clk_ff  <= 1'b0;
            end
            else if (ext_rise)
            begin
                div_cnt_ff <= div_wrap ? 3'h0 : div_cnt_ff + 3'h1;
                sw_clk_ff  <= div_wrap;
            end
        end
    end

    assign sw_sync_clk_o          = sw_clk_ff;
    assign sync_locked_o          = (div_n != 3'h0);
    assign ac_coupled_clock_sel_o = opcfg_ff[pcr_pkg::AC_BIT-1];

    ////////////////////////////////////////////////////////////////////////////
    // Pin, level outputs and read mux

    assign en_pin_oe_o   = pin_drive;
    assign en_pin_o      = pincfg_ff[pcr_pkg::PIN_LEVEL_BIT];
    assign en_pulldown_o = ~pin_drive;

    assign rail_one_level_code_o = lvl_one_ff;
    assign rail_two_level_code_o = lvl_two_ff;
    assign linear_level_code_o   = lvl_lin_ff;

    always_comb
    begin
        if (ptr == pcr_pkg::OFS_REV)
            rd_data = {pcr_pkg::PRIMARY_REV, pcr_pkg::MINOR_REV, pcr_pkg::VARIANT_CODE};
        else if (ptr == pcr_pkg::OFS_LVL_ONE)
            rd_data = {5'h00, lvl_one_ff};
        else if (ptr == pcr_pkg::OFS_LVL_TWO)
            rd_data = {lvl_two_ff, lvl_lin_ff};
        else if (ptr == pcr_pkg::OFS_RAIL)
            rd_data = {rail_on_ff, good_s, force_sd_ff};
        else if (ptr == pcr_pkg::OFS_OPCFG)
            rd_data = {opcfg_ff, therm_flag_ff};
        else if (ptr == pcr_pkg::OFS_PINCFG)
            rd_data = {6'h00, pincfg_ff};
        else
            rd_data = 8'h00;
    end

endmodule

// [rtl/pcr_pkg.sv]
// Constants shared by the power control register bank
package pcr_pkg;

    // Serial slave address, seven bits
    localparam logic [6:0] DEV_ADDR      = 7'h14;

    // Register offsets
    localparam logic [7:0] OFS_REV       = 8'h00;
    localparam logic [7:0] OFS_LVL_ONE   = 8'h01;
    localparam logic [7:0] OFS_LVL_TWO   = 8'h02;
    localparam logic [7:0] OFS_RAIL      = 8'h03;
    localparam logic [7:0] OFS_OPCFG     = 8'h04;
    localparam logic [7:0] OFS_PINCFG    = 8'h05;

    // Revision fields, values arbitrary
    localparam logic [2:0] PRIMARY_REV   = 3'h1;
    localparam logic [2:0] MINOR_REV     = 3'h0;
    localparam logic [1:0] VARIANT_CODE  = 2'h0;

    // Field positions
    localparam int RAIL_ON_MSB           = 7;
    localparam int RAIL_ON_LSB           = 4;
    localparam int RAIL_ALL_BIT          = 4;
    localparam int FORCE_SD_BIT          = 0;
    localparam int DIV3_BIT              = 6;
    localparam int DIV6_BIT              = 5;
    localparam int AC_BIT                = 4;
    localparam int LINK_MSB              = 3;
    localparam int LINK_LSB              = 1;
    localparam int THERM_BIT             = 0;
    localparam int PIN_DRIVE_BIT         = 1;
    localparam int PIN_LEVEL_BIT         = 0;

    // Values after reset
    localparam logic [2:0] RST_LVL_ONE   = 3'h5;
    localparam logic [3:0] RST_LVL_TWO   = 4'h9;
    localparam logic [3:0] RST_LVL_LIN   = 4'h0;
    localparam logic [3:0] RST_RAIL_ON   = 4'h0;
    localparam logic [6:0] RST_OPCFG     = 7'h00;
    localparam logic [1:0] RST_PINCFG    = 2'h0;

    // Sync divider ratios
    localparam logic [2:0] DIV_THREE     = 3'h3;
    localparam logic [2:0] DIV_SIX       = 3'h6;

    // Startup sequence step time
    localparam int CLK_PERIOD_NS         = 4;
    localparam int SEQ_STEP_NS           = 100000;
    localparam int SEQ_STEP_CYC          = SEQ_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0]
    {
        SL_IDLE  = 3'b000,
        SL_ADDR  = 3'b001,
        SL_AACK  = 3'b010,
        SL_RX    = 3'b011,
        SL_RXACK = 3'b100,
        SL_TX    = 3'b101,
        SL_TXACK = 3'b110
    } pcr_slave_e;

    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_ONE  = 2'b01,
        SEQ_TWO  = 2'b10,
        SEQ_ALL  = 2'b11
    } pcr_seq_e;

endpackage

// [rtl/pcr_i2c_slave.sv]
// Serial two-wire slave: address match, register pointer, byte moves
`timescale 1ns/1ps
module pcr_i2c_slave
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       nack_i,
    input  wire logic [7:0] rd_data_i,
    output logic            sda_oe_o,
    output logic [7:0]      ptr_o,
    output logic            wr_o,
    output logic [7:0]      wr_addr_o,
    output logic [7:0]      wr_data_o
);

    pcr_pkg::pcr_slave_e state_ff;
    logic [2:0]          bit_cnt_ff;
    logic [7:0]          shift_ff;
    logic [7:0]          ptr_ff;
    logic                rw_ff;
    logic                first_ff;
    logic                mnak_ff;
    logic                sda_oe_ff;
    logic                scl_d_ff;
    logic                sda_d_ff;
    logic                wr_ff;
    logic [7:0]          wr_addr_ff;
    logic [7:0]          wr_data_ff;

    wire scl_rise = scl_i & ~scl_d_ff;
    wire scl_fall = ~scl_i & scl_d_ff;
    wire start_c  = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
    wire stop_c   = scl_i & scl_d_ff & ~sda_d_ff & sda_i;
    wire addr_hit = (shift_ff[7:1] == pcr_pkg::DEV_ADDR);

    assign sda_oe_o  = sda_oe_ff;
    assign ptr_o     = ptr_ff;
    assign wr_o      = wr_ff;
    assign wr_addr_o = wr_addr_ff;
    assign wr_data_o = wr_data_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine; bits move on SCL falling, samples on SCL rising
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff   <= pcr_pkg::SL_IDLE;
            bit_cnt_ff <= 3'h0;
            shift_ff   <= 8'h00;
            ptr_ff     <= 8'h00;
            rw_ff      <= 1'b0;
            first_ff   <= 1'b0;
            mnak_ff    <= 1'b0;
            sda_oe_ff  <= 1'b0;
            scl_d_ff   <= 1'b1;
            sda_d_ff   <= 1'b1;
            wr_ff      <= 1'b0;
            wr_addr_ff <= 8'h00;
            wr_data_ff <= 8'h00;
        end
        else
        begin
            scl_d_ff <= scl_i;
            sda_d_ff <= sda_i;
            wr_ff    <= 1'b0;
            if (start_c)
            begin
                state_ff   <= pcr_pkg::SL_ADDR;
                bit_cnt_ff <= 3'h7;
                first_ff   <= 1'b1;
                sda_oe_ff  <= 1'b0;
            end
            else if (stop_c)
            begin
                state_ff  <= pcr_pkg::SL_IDLE;
                sda_oe_ff <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (state_ff == pcr_pkg::SL_ADDR || state_ff == pcr_pkg::SL_RX)
                    shift_ff <= {shift_ff[6:0], sda_i};
                if (state_ff == pcr_pkg::SL_TXACK)
                    mnak_ff <= sda_i;
            end
            else if (scl_fall)
            begin
                case (state_ff)
                    pcr_pkg::SL_ADDR:
                        if (first_ff)
                            first_ff <= 1'b0;
                        else if (bit_cnt_ff == 3'h0)
                        begin
                            // Fault withholds the acknowledge
                            if (addr_hit && !nack_i)
                            begin
                                state_ff  <= pcr_pkg::SL_AACK;
                                sda_oe_ff <= 1'b1;
                                rw_ff     <= shift_ff[0];
                            end
                            else
                                state_ff <= pcr_pkg::SL_IDLE;
                        end
                        else
                            bit_cnt_ff <= bit_cnt_ff - 3'h1;
                    pcr_pkg::SL_AACK:
                    begin
                        bit_cnt_ff <= 3'h7;
                        if (rw_ff)
                        begin
                            state_ff  <= pcr_pkg::SL_TX;
                            shift_ff  <= rd_data_i;
                            sda_oe_ff <= ~rd_data_i[7];
                        end
                        else
                        begin
                            state_ff  <= pcr_pkg::SL_RX;
                            first_ff  <= 1'b1;
                            sda_oe_ff <= 1'b0;
                        end
                    end
                    pcr_pkg::SL_RX:
                        if (bit_cnt_ff == 3'h0)
                        begin
                            if (nack_i)
                                state_ff <= pcr_pkg::SL_IDLE;
                            else
                            begin
                                state_ff  <= pcr_pkg::SL_RXACK;
                                sda_oe_ff <= 1'b1;
                                first_ff  <= 1'b0;
                                if (first_ff)
                                    ptr_ff <= shift_ff;
                                else
                                begin
                                    wr_ff      <= 1'b1;
                                    wr_addr_ff <= ptr_ff;
                                    wr_data_ff <= shift_ff;
                                    ptr_ff     <= ptr_ff + 8'h01;
                                end
                            end
                        end
                        else
                            bit_cnt_ff <= bit_cnt_ff - 3'h1;
                    pcr_pkg::SL_RXACK:
                    begin
                        state_ff   <= pcr_pkg::SL_RX;
                        bit_cnt_ff <= 3'h7;
                        sda_oe_ff  <= 1'b0;
                    end
                    pcr_pkg::SL_TX:
                        if (bit_cnt_ff == 3'h0)
                        begin
                            state_ff  <= pcr_pkg::SL_TXACK;
                            sda_oe_ff <= 1'b0;
                            ptr_ff    <= ptr_ff + 8'h01;
                        end
                        else
                        begin
                            bit_cnt_ff <= bit_cnt_ff - 3'h1;
                            shift_ff   <= {shift_ff[6:0], 1'b0};
                            sda_oe_ff  <= ~shift_ff[6];
                        end
                    pcr_pkg::SL_TXACK:
                        if (mnak_ff)
                            state_ff <= pcr_pkg::SL_IDLE;
                        else
                        begin
                            state_ff   <= pcr_pkg::SL_TX;
                            bit_cnt_ff <= 3'h7;
                            shift_ff   <= rd_data_i;
                            sda_oe_ff  <= ~rd_data_i[7];
                        end
                    default:
                        state_ff <= pcr_pkg::SL_IDLE;
                endcase
            end
        end
    end

endmodule

// [test/pcr_top_monitor.sv]
// Checker of the fault, pin and current-limit outputs
`timescale 1ns/1ps
module pcr_top_monitor
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       sda_o,
    input wire logic       supply_low_lockout_i,
    input wire logic       over_temp_i,
    input wire logic [1:0] peak_limit_i,
    input wire logic       en_pin_oe_o,
    input wire logic       en_pulldown_o,
    input wire logic [2:0] rail_on_o,
    input wire logic [1:0] high_side_block_o,
    input wire logic [1:0] low_side_hold_o,
    input wire logic       shutdown_out_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_sda_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
    a_pulldown_input: assert property (en_pulldown_o != en_pin_oe_o) else $error("pulldown wrong");
    a_switch_pair: assert property (high_side_block_o == low_side_hold_o) else $error("switch pair");
    a_limit_one_off: assert property ($rose(peak_limit_i[0]) |-> ##[1:5] high_side_block_o[0])
        else $error("high side one on");
    a_limit_two_off: assert property ($rose(peak_limit_i[1]) |-> ##[1:5] high_side_block_o[1])
        else $error("high side two on");
    a_hot_rails_off: assert property (over_temp_i [*6] |-> rail_on_o == 3'h0) else $error("rails on hot");
    a_hot_shutdown: assert property (over_temp_i [*6] |-> !shutdown_out_n_o) else $error("no shutdown");
    a_lockout_off: assert property (supply_low_lockout_i [*6] |-> rail_on_o == 3'h0)
        else $error("lockout rails on");
endmodule
bind pcr_top pcr_top_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .sda_o(sda_o),
    .supply_low_lockout_i(supply_low_lockout_i), .over_temp_i(over_temp_i), .peak_limit_i(peak_limit_i),
    .en_pin_oe_o(en_pin_oe_o), .en_pulldown_o(en_pulldown_o), .rail_on_o(rail_on_o),
    .high_side_block_o(high_side_block_o), .low_side_hold_o(low_side_hold_o), .shutdown_out_n_o(shutdown_out_n_o));

// [test/pcr_host_model.sv]
// Serial bus master standing in for the host processor
`timescale 1ns/1ps
module pcr_host_model
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o = 1'b1,
    output logic      sda_low_o = 1'b0
);
    logic [8:0] s;
    // Six cycles a phase outlast the input sync
    task automatic ph(input logic c, input logic d);
        scl_o = c;
        sda_low_o = !d;
        repeat (6) @(posedge clk_i);
        #1;
        s = c ? {s[7:0], sda_i} : s;
    endtask
    task automatic xfer(input logic [7:0] b [3], input int n, output logic ok, output logic [7:0] q);
        logic [8:0] v;
        ok = 1'b1;
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            v = {b[i], 1'b1};
            for (int k = 8; k >= 0; k--)
            begin
                ph(1'b0, v[k]);
                ph(1'b1, v[k]);
                ph(1'b0, v[k]);
            end
            ok = ok & ((b[0][0] && i > 0) || !s[0]);
        end
        q = s[8:1];
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
endmodule

// [test/pcr_top_tb.sv]
// Self-checking bench of the power unit control block
`timescale 1ns/1ps
module pcr_top_tb;
    logic       clk_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       sync = 1'b0, low = 1'b0, hot = 1'b0, en = 1'b0, ok;
    logic [1:0] peak = 2'h0, zero = 2'h0, hsb;
    logic       scl, sda_low, sda_oe, en_o, en_oe, ac, lock, sdn;
    logic [2:0] rails;
    logic [7:0] q;
    logic [7:0] cv [4] = '{8'h40, 8'h20, 8'h60, 8'h10};
    logic [8:0] ce [4] = '{9'h2, 9'h2, 9'h0, 9'h1};
    int         fails = 0;
    int         compares = 0;
    wire        sda = !(sda_low || sda_oe);
    wire        en_pin = en_oe ? en_o : en;
    pcr_host_model u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    pcr_top #(.SEQ_STEP_CYC(8)) u_dut
    (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .sync_clk_i(sync), .supply_low_lockout_i(low), .over_temp_i(hot), .rail_good_i(3'h5),
        .peak_limit_i(peak), .coil_zero_i(zero), .en_pin_i(en_pin), .en_pin_o(en_o), .en_pin_oe_o(en_oe),
        .en_pulldown_o(), .rail_on_o(rails), .high_side_block_o(hsb), .low_side_hold_o(),
        .shutdown_out_n_o(sdn), .sw_sync_clk_o(), .sync_locked_o(lock), .ac_coupled_clock_sel_o(ac),
        .rail_one_level_code_o(), .rail_two_level_code_o(), .linear_level_code_o()
    );
    initial forever #2 clk_i = ~clk_i;
    always #52 sync = ~sync;
    ////////////////////////////////////////////////////////////////
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Write echoes data: one compare for both
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic r, input logic e);
        u_host.xfer('{{pcr_pkg::DEV_ADDR, 1'b0}, a, d}, r ? 2 : 3, ok, q);
        if (r)
            u_host.xfer('{{pcr_pkg::DEV_ADDR, 1'b1}, 8'hff, 8'h00}, 2, ok, q);
        chk({ok, q}, {e, d});
        w(4);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        w(20);
        nrst_i = 1'b1;
        w(8);
        op(8'h00, {pcr_pkg::PRIMARY_REV, pcr_pkg::MINOR_REV, pcr_pkg::VARIANT_CODE}, 1, 1);
        u_host.xfer('{8'h2a, 8'h00, 8'h00}, 3, ok, q);
        chk({ok, q}, 9'h0);
        for (int i = 0; i < 4; i++)
        begin
            op(8'h04, cv[i], 0, 1);
            chk(9'({lock, ac}), ce[i]);
        end
        op(8'h03, 8'h80, 0, 1);
        op(8'h03, 8'h8a, 1, 1);
        $display("test registers done");
        hot = 1'b1;
        w(9);
        chk(9'({sdn, rails}), 9'h0);
        op(8'h05, 8'h00, 0, 0);
        hot = 1'b0;
        w(9);
        op(8'h04, 8'h11, 1, 1);
        op(8'h03, 8'h80, 0, 1);
        chk(9'(rails), 9'h0);
        op(8'h04, 8'h00, 0, 1);
        op(8'h03, 8'h80, 0, 1);
        chk(9'(rails), 9'h1);
        op(8'h04, 8'h01, 0, 1);
        chk(9'({sdn, rails}), 9'h8);
        op(8'h04, 8'h00, 0, 1);
        en = 1'b1;
        w(40);
        chk(9'(rails), 9'h7);
        hot = 1'b1;
        w(9);
        hot = 1'b0;
        w(40);
        chk(9'(rails), 9'h7);
        op(8'h04, 8'h01, 1, 1);
        $display("test thermal done");
        op(8'h05, 8'h03, 0, 1);
        chk(9'({en_oe, en_o}), 9'h3);
        low = 1'b1;
        w(9);
        chk(9'({sdn, rails}), 9'h0);
        low = 1'b0;
        peak = 2'h3;
        w(6);
        peak = 2'h0;
        w(6);
        chk(9'(hsb), 9'h3);
        zero = 2'h3;
        w(6);
        chk(9'(hsb), 9'h0);
        $display("test pins done");
        tally_and_finish();
    end
endmodule
